// File: src/flow_hash.sv
// Flow hash: folds enabled flow fields into a 4-bit code.
// Frame fields are same-clock inputs; the random source free-runs.
`timescale 1ns/1ps
`default_nettype none
`include "lag_cfg.svh"
module flow_hash
  import lag_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire frame_s frame,
  input wire hash_cfg_s cfg,
  output logic [3:0] code,
  output logic [3:0] random_code
);
  logic [15:0] lfsr_q;
  logic [3:0] h;

  function automatic logic [3:0] fold(input logic [63:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++)
    begin
      r = r ^ v[i*4 +: 4];
    end
    return r;
  endfunction

  // Free-running so a random code costs no extra state per frame
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lfsr_q <= `LFSR_SEED;
    else
      lfsr_q <= {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? `LFSR_TAPS : 16'h0000);
  end

  assign random_code = lfsr_q[3:0];

  // Pure function of the frame and cfg: one flow always gets one code per cfg setting
  always_comb
  begin
    h = 4'h0;
    if (cfg.hash_use_source_mac) //RQ11
      h = h ^ fold({16'h0000, frame.smac});
    if (cfg.hash_use_dest_mac) //RQ11
      h = h ^ fold({16'h0000, frame.dmac});
    if (cfg.hash_use_v4_addresses && frame.is_v4) //RQ11
      h = h ^ fold({frame.sip, frame.dip});
    if (cfg.hash_use_l4_ports && frame.is_v4 && frame.has_l4) //RQ11
      h = h ^ fold({32'h0, frame.sport, frame.dport});
    if (cfg.hash_use_v6_l4_ports && frame.is_v6 && frame.has_l4) //RQ11
      h = h ^ fold({32'h0, frame.sport, frame.dport});
    if (cfg.hash_use_v6_flow_label && frame.is_v6) //RQ11
      h = h ^ fold({44'h0, frame.flow_label});
  end

  assign code = cfg.hash_use_random ? random_code : h; //RQ10 RQ12
endmodule
`default_nettype wire

// File: src/lag_cfg.svh
// Constants of the forwarding-decision block: offsets, fields, resets.
// Included by the package and the design modules; definitions only.
`ifndef LAG_CFG_SVH
`define LAG_CFG_SVH
`define NPORT 27
`define PW 5
`define MASK_N 107
`define MIW 7
`define AW 12
`define OFS_PORT 12'h000
`define OFS_GLOBAL 12'h080
`define OFS_HASH 12'h084
`define OFS_STATUS 12'h088
`define OFS_MASK 12'h400
`define AGGR_BASE 7'h40
`define SRC_BASE 7'h50
`define RSV_DMAC 48'h0180C2000003
`define PCFG_W 13
`define PCFG_WMASK 13'h1F1F
`define HCFG_W 7
`define HCFG_RST 7'h00
`define QW 3
`define G_RQ 2:0
`define G_LQ 6:4
`define G_NOLEARN 8
`define MASK_DST_RST 27'h0000000
`define MASK_ALL 27'h7FFFFFF
`define LFSR_SEED 16'hACE1
`define LFSR_TAPS 16'hB400
`define CNT_W 16
`endif

// File: src/lag_mac_access.sv
// Forwarding decision: MAC access control and link aggregation.
// AHB-Lite slave for configuration; frame descriptors on hclk.
// Operation
// (RQ1) Redirect reserved address 3 frames to host
// (RQ2) Redirected frames use configured host queue
// (RQ3) Software sets learn, copy, drop; no auto; code still offers hardware_auto_insert per port
// (RQ4) Forward only frames from authenticated sources
// (RQ5) Secure learning: unknown sources go to host
// (RQ6) No-learning: unknown sources silently discarded
// (RQ7) Host inserts authenticated station into table
// (RQ8) Station starts authentication to reserved address
// (RQ9) 4-bit code picks one member port
// (RQ10) Code is deterministic per flow
// (RQ11) Six hash inputs each gated by enable
// (RQ12) Random enable replaces hash with random code
// (RQ13) Software enables all six contributions identically
// (RQ14) Groups up to 16 members, any count
// (RQ15) One group per port, equal speeds
// (RQ16) Members share one logical port number
// (RQ17) Destination masks hold all group members
// (RQ18) Source masks exclude own group members
// (RQ19) Aggregation masks pick one member per code
// (RQ20) Egress is destination, source, aggregation AND
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lag_cfg.svh"
module lag_mac_access
  import lag_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic frame_valid,
  input wire frame_s frame,
  output logic dec_valid,
  output decision_s dec
);
  bus_state_e st_q;
  logic wr_q;
  logic [`AW-1:0] wa_q;
  logic [`AW-1:0] ra_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic hresp_q;
  port_cfg_s port_cfg_q [`NPORT];
  logic [`QW-1:0] rsv_queue_q;
  logic [`QW-1:0] learn_queue_q;
  logic no_learn_q;
  hash_cfg_s hash_cfg_q;
  logic [3:0] last_code_q;
  logic [`CNT_W-1:0] host_cnt_q;
  logic dec_valid_q;
  decision_s dec_q;
  decision_s dec_d;
  logic accept;
  logic [31:0] rword;
  port_cfg_s pc;
  logic [3:0] code;
  logic [3:0] random_code;
  logic [3:0][`MIW-1:0] raddr;
  logic [3:0][`NPORT-1:0] rdata;
  logic rsv_hit;
  logic unl_hit;
  logic [`NPORT-1:0] fwd_mask;

  function automatic logic is_port(input logic [`AW-1:0] a);
    return (a[11:7] == 5'h00) && (a[6:2] < `NPORT);
  endfunction

  function automatic logic is_mask(input logic [`AW-1:0] a);
    return (a[11:9] == `OFS_MASK >> 9) && (a[8:2] < `MASK_N);
  endfunction

  // Only whole-word single transfers are expected, hsize is not decoded
  assign accept = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_q <= BUS_IDLE;
    else
    begin
      case (st_q)
        BUS_IDLE:
          if (accept && !hwrite)
            st_q <= BUS_RWAIT;
        BUS_RWAIT:
          st_q <= BUS_IDLE;
        default:
          st_q <= BUS_IDLE;
      endcase
    end
  end

  // Reads take one wait state so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      wr_q <= 1'b0;
      wa_q <= `OFS_PORT;
      ra_q <= `OFS_PORT;
    end
    else
    begin
      hreadyout_q <= !(accept && !hwrite);
      hresp_q <= 1'b0;
      wr_q <= accept && hwrite;
      if (accept && hwrite)
        wa_q <= haddr[`AW-1:0];
      if (accept && !hwrite)
        ra_q <= haddr[`AW-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h00000000;
    else if (st_q == BUS_RWAIT)
      hrdata_q <= rword;
  end

  for (genvar p = 0; p < `NPORT; p++)
  begin : g_port
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        port_cfg_q[p] <= '{logical_port_number: `PW'(p), default: '0};
      else if (wr_q && is_port(wa_q) && wa_q[6:2] == `PW'(p))
        port_cfg_q[p] <= port_cfg_s'(hwdata[`PCFG_W-1:0] & `PCFG_WMASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rsv_queue_q <= '0;
      learn_queue_q <= '0;
      no_learn_q <= 1'b0;
    end
    else if (wr_q && wa_q == `OFS_GLOBAL)
    begin
      rsv_queue_q <= hwdata[`G_RQ];
      learn_queue_q <= hwdata[`G_LQ];
      no_learn_q <= hwdata[`G_NOLEARN];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hash_cfg_q <= `HCFG_RST;
    else if (wr_q && wa_q == `OFS_HASH)
      hash_cfg_q <= hash_cfg_s'(hwdata[`HCFG_W-1:0]);
  end

  always_comb
  begin
    rword = 32'h00000000;
    if (is_port(ra_q))
      rword = {19'h00000, port_cfg_q[ra_q[6:2]]};
    else if (is_mask(ra_q))
      rword = {5'h00, rdata[3]};
    else if (ra_q == `OFS_GLOBAL)
      rword = {23'h000000, no_learn_q, 1'b0, learn_queue_q, 1'b0, rsv_queue_q};
    else if (ra_q == `OFS_HASH)
      rword = {25'h0000000, hash_cfg_q};
    else if (ra_q == `OFS_STATUS)
      rword = {host_cnt_q, 12'h000, last_code_q};
  end

  flow_hash u_hash (
    .hclk(hclk),
    .hresetn(hresetn),
    .frame(frame),
    .cfg(hash_cfg_q),
    .code(code),
    .random_code(random_code)
  );

  // Out-of-range ingress ports see an all-zero source mask
  assign raddr[0] = {1'b0, frame.dest_index};
  assign raddr[1] = `AGGR_BASE + {3'b000, code}; //RQ9 RQ14
  assign raddr[2] = `SRC_BASE + `MIW'(frame.src_port);
  assign raddr[3] = ra_q[8:2];

  port_mask_table u_masks (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(wr_q && is_mask(wa_q)),
    .waddr(wa_q[8:2]),
    .wdata(hwdata[`NPORT-1:0]),
    .raddr(raddr),
    .rdata(rdata)
  );

  assign pc = (frame.src_port < `NPORT) ? port_cfg_q[frame.src_port] : '0;
  assign rsv_hit = pc.reserved_mac_redirect_enable && frame.dmac == `RSV_DMAC; //RQ1
  assign unl_hit = !frame.smac_known && pc.address_learning_on
    && pc.drop_unlearned_source; //RQ4
  assign fwd_mask = rdata[0] & rdata[2] & rdata[1]; //RQ20

  // Reserved-address redirect outranks source checks so unknown stations
  // can still reach the host to authenticate
  always_comb
  begin
    dec_d = '0;
    dec_d.flow_hash_code = code; //RQ9
    dec_d.logical_port_number = pc.logical_port_number;
    dec_d.hw_insert = !frame.smac_known && pc.address_learning_on
      && pc.hardware_auto_insert;
    if (rsv_hit)
    begin
      dec_d.to_host = 1'b1; //RQ1
      dec_d.host_queue = rsv_queue_q; //RQ2
    end
    else if (unl_hit)
    begin
      if (pc.copy_new_source_to_host && !no_learn_q)
      begin
        dec_d.to_host = 1'b1; //RQ5
        dec_d.learn = 1'b1;
        dec_d.host_queue = learn_queue_q;
      end
      else
        dec_d.drop = 1'b1; //RQ6
    end
    else
    begin
      dec_d.egress = fwd_mask; //RQ20
      dec_d.drop = (fwd_mask == '0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dec_valid_q <= 1'b0;
      dec_q <= '0;
    end
    else
    begin
      dec_valid_q <= frame_valid;
      if (frame_valid)
        dec_q <= dec_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_code_q <= 4'h0;
      host_cnt_q <= '0;
    end
    else if (frame_valid)
    begin
      last_code_q <= code;
      if (dec_d.to_host)
        host_cnt_q <= host_cnt_q + `CNT_W'(1);
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign dec_valid = dec_valid_q;
  assign dec = dec_q;

  property p_redirect;
    @(posedge hclk) disable iff (!hresetn)
    frame_valid && rsv_hit |=> dec_valid && dec.to_host && dec.egress == '0;
  endproperty
  a_redirect: assert property (p_redirect) else $error("reserved frame not redirected"); //RQ1

  property p_queue;
    @(posedge hclk) disable iff (!hresetn)
    frame_valid && rsv_hit ##1 1'b1 |-> dec.host_queue == $past(rsv_queue_q);
  endproperty
  a_queue: assert property (p_queue) else $error("wrong host queue"); //RQ2

  property p_unknown_blocked;
    @(posedge hclk) disable iff (!hresetn)
    frame_valid && unl_hit && !rsv_hit |=> dec.egress == '0 && !dec.hw_insert;
  endproperty
  a_unknown_blocked: assert property (p_unknown_blocked) else $error("unknown forwarded"); //RQ4

  property p_learn_frame;
    @(posedge hclk) disable iff (!hresetn)
    frame_valid && unl_hit && !rsv_hit && pc.copy_new_source_to_host && !no_learn_q
      |=> dec.to_host && dec.learn && dec.host_queue == $past(learn_queue_q);
  endproperty
  a_learn_frame: assert property (p_learn_frame) else $error("no learn frame"); //RQ5

  property p_discard;
    @(posedge hclk) disable iff (!hresetn)
    frame_valid && unl_hit && !rsv_hit && no_learn_q |=> dec.drop && !dec.to_host;
  endproperty
  a_discard: assert property (p_discard) else $error("unknown not discarded"); //RQ6

  property p_one_member;
    @(posedge hclk) disable iff (!hresetn)
    frame_valid && !rsv_hit && !unl_hit
      |=> (dec.egress & ~$past(rdata[1])) == '0 && dec.drop == (dec.egress == '0);
  endproperty
  a_one_member: assert property (p_one_member) else $error("egress outside code mask"); //RQ9

  property p_same_flow;
    @(posedge hclk) disable iff (!hresetn)
    frame_valid && !hash_cfg_q.hash_use_random
      ##1 frame_valid && frame == $past(frame) && $stable(hash_cfg_q)
      |=> dec.flow_hash_code == $past(dec.flow_hash_code);
  endproperty
  a_same_flow: assert property (p_same_flow) else $error("flow code changed"); //RQ10

  property p_no_inputs;
    @(posedge hclk) disable iff (!hresetn)
    frame_valid && hash_cfg_q == `HCFG_RST |=> dec.flow_hash_code == 4'h0;
  endproperty
  a_no_inputs: assert property (p_no_inputs) else $error("disabled inputs hashed"); //RQ11

  property p_random;
    @(posedge hclk) disable iff (!hresetn)
    frame_valid && hash_cfg_q.hash_use_random
      |=> dec.flow_hash_code == $past(random_code);
  endproperty
  a_random: assert property (p_random) else $error("random code not used"); //RQ12

  property p_and_masks;
    @(posedge hclk) disable iff (!hresetn)
    frame_valid && !rsv_hit && !unl_hit
      |=> dec.egress == $past(rdata[0] & rdata[2] & rdata[1]);
  endproperty
  a_and_masks: assert property (p_and_masks) else $error("egress not mask AND"); //RQ20
endmodule
`default_nettype wire

// File: src/lag_pkg.sv
// Types shared by the forwarding-decision modules.
// Widths come from lag_cfg.svh.
`include "lag_cfg.svh"
package lag_pkg;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_RWAIT = 2'b10} bus_state_e;
  typedef struct packed {
    logic [`PW-1:0] src_port;
    logic [47:0] dmac;
    logic [47:0] smac;
    logic is_v4;
    logic is_v6;
    logic has_l4;
    logic [31:0] sip;
    logic [31:0] dip;
    logic [15:0] sport;
    logic [15:0] dport;
    logic [19:0] flow_label;
    logic [5:0] dest_index;
    logic smac_known;
  } frame_s;
  typedef struct packed {
    logic [`PW-1:0] logical_port_number;
    logic [2:0] rsvd;
    logic hardware_auto_insert;
    logic drop_unlearned_source;
    logic copy_new_source_to_host;
    logic address_learning_on;
    logic reserved_mac_redirect_enable;
  } port_cfg_s;
  typedef struct packed {
    logic hash_use_random;
    logic hash_use_v6_flow_label;
    logic hash_use_v6_l4_ports;
    logic hash_use_l4_ports;
    logic hash_use_v4_addresses;
    logic hash_use_dest_mac;
    logic hash_use_source_mac;
  } hash_cfg_s;
  typedef struct packed {
    logic [`NPORT-1:0] egress;
    logic to_host;
    logic [`QW-1:0] host_queue;
    logic learn;
    logic hw_insert;
    logic drop;
    logic [`PW-1:0] logical_port_number;
    logic [3:0] flow_hash_code;
  } decision_s;
endpackage

// File: src/port_mask_table.sv
// Port group mask table: destination, aggregation and source masks.
// One write port from the bus, four asynchronous read ports.
`timescale 1ns/1ps
`default_nettype none
`include "lag_cfg.svh"
module port_mask_table
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we,
  input wire logic [`MIW-1:0] waddr,
  input wire logic [`NPORT-1:0] wdata,
  input wire logic [3:0][`MIW-1:0] raddr,
  output logic [3:0][`NPORT-1:0] rdata
);
  logic [`NPORT-1:0] mem_q [`MASK_N];

  // Aggregation and source masks open at reset, destinations closed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < `MASK_N; i++)
      begin
        mem_q[i] <= (i >= `AGGR_BASE) ? `MASK_ALL : `MASK_DST_RST;
      end
    end
    else if (we)
      mem_q[waddr] <= wdata;
  end

  for (genvar r = 0; r < 4; r++)
  begin : g_rd
    assign rdata[r] = (raddr[r] < `MASK_N) ? mem_q[raddr[r]] : `MASK_DST_RST;
  end
endmodule
`default_nettype wire

// File: tb/frame_source.sv
// Partner model: the ingress ports handing frame descriptors to the block.
// Assumes the block takes a descriptor on any rising edge with frame_valid.
`timescale 1ns/1ps
`default_nettype none
module frame_source
  import lag_pkg::*;
(
  input wire logic hclk,
  output logic frame_valid,
  output frame_s frame
);
  initial
  begin
    frame_valid = 1'b0;
    frame = '0;
  end
  // Idle descriptor is inverted so a stale frame never passes for a new one
  task automatic send(input frame_s f);
    @(posedge hclk);
    frame_valid <= 1'b1;
    frame <= f;
    @(posedge hclk);
    frame_valid <= 1'b0;
    frame <= ~f;
    #1;
  endtask
  // Same descriptor on two consecutive edges, the only back-to-back case
  task automatic send_twice(input frame_s f);
    @(posedge hclk);
    frame_valid <= 1'b1;
    frame <= f;
    repeat (2) @(posedge hclk);
    frame_valid <= 1'b0;
    frame <= ~f;
    #1;
  endtask
endmodule
`default_nettype wire

// File: tb/test_lag_mac_access.sv
// Testbench: configures the block over the bus and checks frame decisions.
// Assumes the frame_source partner model and the shared cfg header.
`timescale 1ns/1ps
`default_nettype none
`include "lag_cfg.svh"
module test_lag_mac_access
  import lag_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic frame_valid;
  frame_s frame;
  logic dec_valid;
  decision_s dec;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int diff;
  logic [3:0] first;
  frame_s fx;

  always #25 hclk = ~hclk;

  lag_mac_access lag_mac_access_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .frame_valid(frame_valid), .frame(frame), .dec_valid(dec_valid), .dec(dec)
  );

  frame_source frame_source_i (.hclk(hclk), .frame_valid(frame_valid), .frame(frame));

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Cuts a hung handshake short; the whole run needs well under 2000 cycles
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Waits on hready with no assumed latency; only the timeout ends a wait
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  function automatic frame_s mk(input logic [4:0] p, input logic [47:0] d,
                                input logic [47:0] s, input logic k, input logic [5:0] di);
    mk = '0;
    mk.src_port = p;
    mk.dmac = d;
    mk.smac = s;
    mk.smac_known = k;
    mk.dest_index = di;
  endfunction

  task automatic go(input frame_s f, input logic [26:0] eg, input logic h,
                    input logic l, input logic d, input logic [2:0] q);
    frame_source_i.send(f);
    chk({31'h0, dec_valid}, 32'h1);
    chk({5'h0, dec.egress}, {5'h0, eg});
    chk({29'h0, dec.to_host, dec.learn, dec.drop}, {29'h0, h, l, d});
    if (h)
      chk({29'h0, dec.host_queue}, {29'h0, q});
  endtask

  // Member ports 0, 1, 4, 5 take codes by their two low bits
  function automatic int mbr(input logic [3:0] c);
    return c[1] ? (c[0] ? 5 : 4) : (c[0] ? 1 : 0);
  endfunction

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`OFS_PORT + 12'h00C, 32'h0000_0300);
    rdc(`OFS_GLOBAL, 32'h0);
    rdc(`OFS_HASH, 32'h0);
    rdc(`OFS_MASK, 32'h0);
    rdc(`OFS_MASK + 12'h100, {5'h0, `MASK_ALL});
    wr(12'h08C, 32'hFFFF_FFFF);
    rdc(12'h08C, 32'h0);
    wr(`OFS_HASH, 32'hFFFF_FFFF);
    rdc(`OFS_HASH, 32'h0000_007F);
    $display("test registers done");
    wr(`OFS_PORT + 12'h008, 32'h0000_020F);
    wr(`OFS_GLOBAL, 32'h0000_0035);
    go(mk(5'd2, `RSV_DMAC, 48'h1, 1'b0, 6'd1), 27'h0, 1'b1, 1'b0, 1'b0, 3'h5);
    go(mk(5'd2, 48'h10, 48'h1, 1'b0, 6'd1), 27'h0, 1'b1, 1'b1, 1'b0, 3'h3);
    go(mk(5'd3, `RSV_DMAC, 48'h1, 1'b1, 6'd0), 27'h0, 1'b0, 1'b0, 1'b1, 3'h0);
    wr(`OFS_GLOBAL, 32'h0000_0135);
    go(mk(5'd2, 48'h10, 48'h1, 1'b0, 6'd1), 27'h0, 1'b0, 1'b0, 1'b1, 3'h0);
    $display("test access control done");
    wr(`OFS_MASK + 12'h004, 32'h0000_0033);
    for (int c = 0; c < 16; c++)
      wr(`OFS_MASK + 12'(256 + 4 * c), {5'h0, (~27'h33) | (27'h1 << mbr(4'(c)))});
    wr(`OFS_HASH, 32'h1);
    for (int c = 0; c < 16; c++)
      repeat (2)
      begin
        go(mk(5'd2, 48'h10, 48'(c), 1'b1, 6'd1), 27'h1 << mbr(4'(c)), 1'b0, 1'b0, 1'b0,
           3'h0);
        chk({28'h0, dec.flow_hash_code}, 32'(c));
      end
    frame_source_i.send_twice(mk(5'd2, 48'h10, 48'h7, 1'b1, 6'd1));
    chk({31'h0, dec_valid}, 32'h1);
    chk({5'h0, dec.egress}, 32'h20);
    chk({28'h0, dec.flow_hash_code}, 32'h7);
    wr(`OFS_HASH, 32'h3F);
    fx = mk(5'd2, 48'h0, 48'h0, 1'b1, 6'd1);
    fx.is_v4 = 1'b1;
    fx.has_l4 = 1'b1;
    fx.sip = 32'h3;
    fx.sport = 16'h4;
    fx.flow_label = 20'h8;
    go(fx, 27'h20, 1'b0, 1'b0, 1'b0, 3'h0);
    chk({28'h0, dec.flow_hash_code}, 32'h7);
    fx.is_v4 = 1'b0;
    fx.is_v6 = 1'b1;
    go(fx, 27'h1, 1'b0, 1'b0, 1'b0, 3'h0);
    chk({28'h0, dec.flow_hash_code}, 32'hC);
    wr(`OFS_HASH, 32'h2);
    go(mk(5'd2, 48'h5, 48'hA, 1'b1, 6'd1), 27'h2, 1'b0, 1'b0, 1'b0, 3'h0);
    chk({28'h0, dec.flow_hash_code}, 32'h5);
    wr(`OFS_HASH, 32'h0);
    go(mk(5'd2, 48'h5, 48'hA, 1'b1, 6'd1), 27'h1, 1'b0, 1'b0, 1'b0, 3'h0);
    chk({28'h0, dec.flow_hash_code}, 32'h0);
    wr(`OFS_MASK + 12'h140, 32'h07FF_FFCC);
    go(mk(5'd0, 48'h5, 48'hA, 1'b1, 6'd1), 27'h0, 1'b0, 1'b0, 1'b1, 3'h0);
    rdc(`OFS_STATUS, 32'h0002_0000);
    wr(`OFS_PORT + 12'h004, 32'h0000_0000);
    go(mk(5'd1, 48'h5, 48'hA, 1'b1, 6'd1), 27'h1, 1'b0, 1'b0, 1'b0, 3'h0);
    chk({27'h0, dec.logical_port_number}, 32'h0);
    wr(`OFS_PORT + 12'h00C, 32'h0000_0312);
    go(mk(5'd3, 48'h5, 48'hA, 1'b0, 6'd0), 27'h0, 1'b0, 1'b0, 1'b1, 3'h0);
    chk({30'h0, dec.hw_insert, dec.logical_port_number == 5'd3}, 32'h3);
    $display("test aggregation done");
    // Random code cannot be predicted; check it moves and still picks one member
    wr(`OFS_HASH, 32'h41);
    diff = 0;
    for (int i = 0; i < 8; i++)
    begin
      frame_source_i.send(mk(5'd2, 48'h5, 48'hA, 1'b1, 6'd1));
      if (i == 0)
        first = dec.flow_hash_code;
      else if (dec.flow_hash_code !== first)
        diff++;
      chk({5'h0, dec.egress}, {5'h0, 27'h1 << mbr(dec.flow_hash_code)});
    end
    chk(32'(diff > 0), 32'h1);
    $display("test random code done");
    conclude();
  end
endmodule
`default_nettype wire
